// File: rtl/adc_seq_params.svh
// Register offsets, field positions, reset values and timing counts for the ADC sequencer
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// Register offsets
`define OFS_RESULT_LOW 8'hba
`define OFS_RESULT_HIGH 8'hbb
`define OFS_CTRL_FIRST 8'hb4
`define OFS_SEQ_CTRL 8'hb5
`define OFS_EXTRA_CTRL 8'hb6
`define OFS_AIN_CFG 8'hf2

// Control register fields
`define CF_EOC 7
`define CF_ST 6
`define CF_START_SOURCE_SELECT_HI 5
`define CF_START_SOURCE_SELECT_LO 4
`define CF_LOW_RESET 4'h3
`define START_SOURCE_SELECT_RESET 2'h3

// Sequence and extra control fields
`define SC_REF_HI 7
`define SC_REF_LO 6
`define SC_DIV_HI 5
`define SC_DIV_LO 4
`define SC_CH_HI 3
`define SC_CH_LO 0
`define SC_RESET 8'h10
`define EC_RESET 8'h00
`define CFG_RESET 8'h00

// Start source codes
`define START_SOURCE_SELECT_EXT 2'h0
`define START_SOURCE_SELECT_FULL 2'h1
`define START_SOURCE_SELECT_TMR 2'h2
`define START_SOURCE_SELECT_SW 2'h3

// Channel codes
`define CH_FIRST_DIFF 4'h8
`define CH_LAST_SEQ 4'hc

// Converter clock is the system clock divided by this
`define ADC_CLK_DIV 3'h6
`define SETTLE_TICKS 10'h010
`define DEC_64 10'h040
`define DEC_128 10'h080
`define DEC_256 10'h100
`define DEC_512 10'h200

`endif

// File: rtl/adc_seq_pkg.sv
// Types for the ADC sequencer
package adc_seq_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_PICK = 4'b0010,
        ST_CONV = 4'b0100,
        ST_END = 4'b1000
    } seq_state_t;
    typedef logic [3:0] chan_t;
    typedef logic [13:0] result_t;
endpackage : adc_seq_pkg

// File: rtl/adc_sequencer_control.sv
// Digital control of a delta-sigma ADC: sequencing, start sources, results, triggers
//
// How it works
// - Last channel below 8 converts channels 0 up to it in order.
// - Codes 0-7 single pins, 8-11 pin pairs, 12-15 gnd/ref/temp/supply3.
// - Last channel 8-12 starts at 8; above 12 converts only that channel.
// - Sequence skips a channel whose analog input is not enabled.
// - Differential sequence channels need both pins enabled, else skipped.
// - Done flag sets at conversion end, clears on high result read.
// - Software start launches only with source 11 and idle; clears at end.
// - Start source picks pin edge, back to back, timer event or software bit.
// - Source codes: 00 pin, 01 full speed, 10 timer, 11 software bit.
// - Writing extra control starts one conversion with its own fields.
// - Results are two's complement from the converter sample.
// - Low result holds result bits 5:0 in 7:2; bits 1:0 read zero.
// - High result holds result bits 13:6, resets to zero.
// - Reading last-channel field returns channel of held result.
// - Converter clock is system clock divided by 6.
// - Conversion lasts decimation rate plus 16 converter clock periods.
// - Decimation setting also sets resolution, 8 to 13 bits.
// - Interrupt pulses only when an extra conversion completes.
// - DMA trigger pulses for each sequence conversion, never for extra.
// - Eight per-channel DMA triggers, one for each single-ended code.
// - Any-channel DMA trigger pulses for every sequence conversion.
// - Reference select offers internal, supply, input 7, inputs 6-7.
// - Reference codes: 00 internal, 01 input 7, 10 supply, 11 pair 6-7.
`timescale 1ns/1ps
`include "adc_seq_params.svh"

module adc_sequencer_control
    import adc_seq_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Start events
    input wire logic ext_trig_pin_i,
    input wire logic timer_evt_i,
    // Modulator side
    input wire logic [13:0] sample_i,
    output logic [3:0] mux_ch_o,
    output logic [1:0] ref_sel_o,
    output logic [1:0] dec_sel_o,
    output logic conv_run_o,
    output logic adc_clk_en_o,
    // Events
    output logic irq_o,
    output logic [7:0] per_channel_dma_trigger_o,
    output logic any_channel_dma_trigger_o
);

    ////////////////////////////////////////////////////////////////////////
    // Registers and state

    logic eoc_r;
    logic st_r;
    logic [1:0] start_source_select_r;
    logic [3:0] ctrl_low_r;
    logic [7:0] seq_ctrl_r;
    logic [7:0] extra_ctrl_r;
    logic [7:0] ain_cfg_r;
    result_t result_r;
    chan_t result_ch_r;
    logic [7:0] rdata_r;
    seq_state_t state_r;
    chan_t cur_ch_r;
    chan_t last_ch_r;
    logic extra_pend_r;
    logic conv_extra_r;
    logic [1:0] conv_ref_r;
    logic [1:0] conv_div_r;
    logic [2:0] pre_r;
    logic tick_r;
    logic [9:0] tick_cnt_r;
    logic [2:0] pin_sync_r;
    logic pin_level_r;
    logic irq_r;
    logic [7:0] dma_ch_r;
    logic dma_all_r;

    logic wr_ctrl;
    logic wr_extra;
    logic trig_edge;
    logic seq_start;
    logic conv_done;
    logic single_mode;
    logic [9:0] conv_len;

    assign wr_ctrl = wr_i && (addr_i == `OFS_CTRL_FIRST);
    assign wr_extra = wr_i && (addr_i == `OFS_EXTRA_CTRL);

    // Channel usable in a sequence given the input enables
    function automatic logic chan_ok(input chan_t ch, input logic [7:0] cfg);
        logic ok;
        ok = 1'b1;
        if (ch < `CH_FIRST_DIFF) begin
            ok = cfg[ch[2:0]];
        end else if (ch < `CH_LAST_SEQ) begin
            ok = cfg[{ch[1:0], 1'b0}] & cfg[{ch[1:0], 1'b1}];
        end
        return ok;
    endfunction : chan_ok

    ////////////////////////////////////////////////////////////////////////
    // Start sources

    // Pin edge counts once the second and third stages agree
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pin_sync_r <= 3'h0;
            pin_level_r <= 1'b0;
        end else begin
            pin_sync_r <= {pin_sync_r[1:0], ext_trig_pin_i};
            if (pin_sync_r[2] == pin_sync_r[1]) begin
                pin_level_r <= pin_sync_r[2];
            end
        end
    end

    assign trig_edge = (pin_sync_r[2] == pin_sync_r[1]) && pin_sync_r[2] && !pin_level_r;

    always_comb begin
        case (start_source_select_r)
            `START_SOURCE_SELECT_EXT: seq_start = trig_edge;
            `START_SOURCE_SELECT_FULL: seq_start = 1'b1;
            `START_SOURCE_SELECT_TMR: seq_start = timer_evt_i;
            default: seq_start = st_r;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Converter clock and conversion timing

    // Ticks keep running, so a conversion starts at whatever phase the divider is in
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pre_r <= 3'h0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= (pre_r == `ADC_CLK_DIV - 3'h1);
            pre_r <= (pre_r == `ADC_CLK_DIV - 3'h1) ? 3'h0 : pre_r + 3'h1;
        end
    end

    always_comb begin
        case (conv_div_r)
            2'h0: conv_len = `DEC_64 + `SETTLE_TICKS;
            2'h1: conv_len = `DEC_128 + `SETTLE_TICKS;
            2'h2: conv_len = `DEC_256 + `SETTLE_TICKS;
            default: conv_len = `DEC_512 + `SETTLE_TICKS;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            tick_cnt_r <= 10'h000;
        end else if (state_r != ST_CONV) begin
            tick_cnt_r <= 10'h000;
        end else if (tick_r) begin
            tick_cnt_r <= tick_cnt_r + 10'h001;
        end
    end

    assign conv_done = (state_r == ST_CONV) && tick_r && (tick_cnt_r == conv_len - 10'h001);
    assign single_mode = last_ch_r > `CH_LAST_SEQ;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_r <= ST_IDLE;
            cur_ch_r <= 4'h0;
            last_ch_r <= 4'h0;
            conv_extra_r <= 1'b0;
            conv_ref_r <= 2'h0;
            conv_div_r <= 2'h0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (extra_pend_r) begin
                        conv_extra_r <= 1'b1;
                        cur_ch_r <= extra_ctrl_r[`SC_CH_HI:`SC_CH_LO];
                        conv_ref_r <= extra_ctrl_r[`SC_REF_HI:`SC_REF_LO];
                        conv_div_r <= extra_ctrl_r[`SC_DIV_HI:`SC_DIV_LO];
                        state_r <= ST_CONV;
                    end else if (seq_start) begin
                        conv_extra_r <= 1'b0;
                        last_ch_r <= seq_ctrl_r[`SC_CH_HI:`SC_CH_LO];
                        conv_ref_r <= seq_ctrl_r[`SC_REF_HI:`SC_REF_LO];
                        conv_div_r <= seq_ctrl_r[`SC_DIV_HI:`SC_DIV_LO];
                        if (seq_ctrl_r[`SC_CH_HI:`SC_CH_LO] < `CH_FIRST_DIFF) begin
                            cur_ch_r <= 4'h0;
                        end else if (seq_ctrl_r[`SC_CH_HI:`SC_CH_LO] <= `CH_LAST_SEQ) begin
                            cur_ch_r <= `CH_FIRST_DIFF;
                        end else begin
                            cur_ch_r <= seq_ctrl_r[`SC_CH_HI:`SC_CH_LO];
                        end
                        state_r <= ST_PICK;
                    end
                end
                ST_PICK: begin
                    if (single_mode || chan_ok(cur_ch_r, ain_cfg_r)) begin
                        state_r <= ST_CONV;
                    end else if (cur_ch_r == last_ch_r) begin
                        state_r <= ST_END;
                    end else begin
                        cur_ch_r <= cur_ch_r + 4'h1;
                    end
                end
                ST_CONV: begin
                    if (conv_done) begin
                        if (conv_extra_r) begin
                            state_r <= ST_IDLE;
                        end else if (single_mode || cur_ch_r == last_ch_r) begin
                            state_r <= ST_END;
                        end else begin
                            cur_ch_r <= cur_ch_r + 4'h1;
                            state_r <= ST_PICK;
                        end
                    end
                end
                // Sequence over; idle state serves a pending extra first
                ST_END: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Extra request waits for any running conversion or sequence
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            extra_pend_r <= 1'b0;
        end else if (wr_extra) begin
            extra_pend_r <= 1'b1;
        end else if (state_r == ST_IDLE) begin
            extra_pend_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Results and status

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            result_r <= 14'h0000;
            result_ch_r <= 4'h0;
        end else if (conv_done) begin
            case (conv_div_r)
                2'h0: result_r <= {sample_i[13:6], 6'h00};
                2'h1: result_r <= {sample_i[13:4], 4'h0};
                2'h2: result_r <= {sample_i[13:2], 2'h0};
                default: result_r <= {sample_i[13:1], 1'b0};
            endcase
            result_ch_r <= cur_ch_r;
        end
    end

    // A finishing conversion beats the clearing read
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            eoc_r <= 1'b0;
        end else if (conv_done) begin
            eoc_r <= 1'b1;
        end else if (rd_i && addr_i == `OFS_RESULT_HIGH) begin
            eoc_r <= 1'b0;
        end
    end

    // Start bit: accepted only when idle with software source
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            st_r <= 1'b0;
        end else if (state_r == ST_END) begin
            st_r <= 1'b0;
        end else if (wr_ctrl && wdata_i[`CF_ST] && state_r == ST_IDLE
                     && wdata_i[`CF_START_SOURCE_SELECT_HI:`CF_START_SOURCE_SELECT_LO] == `START_SOURCE_SELECT_SW) begin
            st_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register port

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            start_source_select_r <= `START_SOURCE_SELECT_RESET;
            ctrl_low_r <= `CF_LOW_RESET;
            seq_ctrl_r <= `SC_RESET;
            extra_ctrl_r <= `EC_RESET;
            ain_cfg_r <= `CFG_RESET;
        end else if (wr_i) begin
            if (addr_i == `OFS_CTRL_FIRST) begin
                start_source_select_r <= wdata_i[`CF_START_SOURCE_SELECT_HI:`CF_START_SOURCE_SELECT_LO];
                ctrl_low_r <= wdata_i[3:0];
            end else if (addr_i == `OFS_SEQ_CTRL) begin
                seq_ctrl_r <= wdata_i;
            end else if (addr_i == `OFS_EXTRA_CTRL) begin
                extra_ctrl_r <= wdata_i;
            end else if (addr_i == `OFS_AIN_CFG) begin
                ain_cfg_r <= wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rdata_r <= 8'h00;
        end else if (!rd_i) begin
            rdata_r <= 8'h00;
        end else if (addr_i == `OFS_RESULT_LOW) begin
            rdata_r <= {result_r[5:0], 2'h0};
        end else if (addr_i == `OFS_RESULT_HIGH) begin
            rdata_r <= result_r[13:6];
        end else if (addr_i == `OFS_CTRL_FIRST) begin
            rdata_r <= {eoc_r, st_r, start_source_select_r, ctrl_low_r};
        end else if (addr_i == `OFS_SEQ_CTRL) begin
            rdata_r <= {seq_ctrl_r[7:4], result_ch_r};
        end else if (addr_i == `OFS_EXTRA_CTRL) begin
            rdata_r <= extra_ctrl_r;
        end else if (addr_i == `OFS_AIN_CFG) begin
            rdata_r <= ain_cfg_r;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            irq_r <= 1'b0;
            dma_ch_r <= 8'h00;
            dma_all_r <= 1'b0;
        end else begin
            irq_r <= conv_done && conv_extra_r;
            dma_all_r <= conv_done && !conv_extra_r;
            for (int i = 0; i < 8; i++) begin
                dma_ch_r[i] <= conv_done && !conv_extra_r
                               && cur_ch_r == 4'(i);
            end
        end
    end

    // Modulator sees settings frozen for the whole conversion
    assign mux_ch_o = cur_ch_r;
    assign ref_sel_o = conv_ref_r;
    assign dec_sel_o = conv_div_r;
    assign conv_run_o = state_r[2];
    assign adc_clk_en_o = tick_r;
    assign rdata_o = rdata_r;
    assign irq_o = irq_r;
    assign per_channel_dma_trigger_o = dma_ch_r;
    assign any_channel_dma_trigger_o = dma_all_r;

endmodule : adc_sequencer_control

// File: sim/adc_mod_model.sv
// Behavioural modulator feeding samples to the sequencer
`timescale 1ns/1ps

module adc_mod_model (
    // Converter control
    input wire logic [3:0] mux_ch_i,
    input wire logic conv_run_i,
    // Test pattern and sample
    input wire logic [13:0] pattern_i,
    output logic [13:0] sample_o
);
    // Channel folded in so a wrong mux shows; inverted when idle so stale capture shows
    assign sample_o = conv_run_i ? (pattern_i ^ {mux_ch_i, 10'h000}) : ~pattern_i;
endmodule : adc_mod_model

// File: sim/adc_seq_checker.sv
// Port-level assertions for the ADC sequencer control block
`timescale 1ns/1ps
`include "adc_seq_params.svh"

module adc_seq_checker (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // Converter and events
    input wire logic [1:0] dec_sel_o,
    input wire logic conv_run_o,
    input wire logic adc_clk_en_o,
    input wire logic irq_o,
    input wire logic [7:0] per_channel_dma_trigger_o,
    input wire logic any_channel_dma_trigger_o
);
    logic [9:0] tick_cnt_r;
    logic [9:0] need;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    ////////////////////////////////////////////////////////////////
    // Ticks seen while a conversion runs, cleared between conversions
    assign need = (10'h040 << dec_sel_o) + 10'h010;
    always_ff @(posedge clk_i) begin
        if (!nrst_i || !conv_run_o) begin
            tick_cnt_r <= 10'h000;
        end else if (adc_clk_en_o) begin
            tick_cnt_r <= tick_cnt_r + 10'h001;
        end
    end

    sequence s_tick_gap;
        !adc_clk_en_o [*5] ##1 adc_clk_en_o;
    endsequence

    ////////////////////////////////////////////////////////////////
    a_tick_gap_six: assert property (adc_clk_en_o |=> s_tick_gap)
        else $error("converter tick spacing wrong");
    // One tick of slack: the start may land either side of a tick
    a_conv_tick_len: assert property ($fell(conv_run_o) |->
        (tick_cnt_r + 10'h001 >= $past(need)) && (tick_cnt_r <= $past(need) + 10'h001))
        else $error("conversion length wrong");
    a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read slot");
    a_low_pad_zero: assert property ($past(rd_i) && $past(addr_i) == `OFS_RESULT_LOW
        |-> rdata_o[1:0] == 2'b00)
        else $error("low result pad bits set");
    a_irq_no_dma: assert property (irq_o |->
        !any_channel_dma_trigger_o && per_channel_dma_trigger_o == 8'h00)
        else $error("dma trigger beside interrupt");
    a_per_any_dma: assert property (per_channel_dma_trigger_o != 8'h00
        |-> any_channel_dma_trigger_o)
        else $error("channel trigger without any trigger");
    a_per_one_hot: assert property (any_channel_dma_trigger_o
        |-> $onehot0(per_channel_dma_trigger_o))
        else $error("several channel triggers");
    a_dma_pulse_short: assert property (any_channel_dma_trigger_o
        |=> !any_channel_dma_trigger_o [*8])
        else $error("dma trigger too long");
    a_irq_pulse_short: assert property ($rose(irq_o) |=> $fell(irq_o))
        else $error("interrupt pulse too long");
endmodule : adc_seq_checker

bind adc_sequencer_control adc_seq_checker i_chk (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .addr_i(addr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .dec_sel_o(dec_sel_o),
    .conv_run_o(conv_run_o),
    .adc_clk_en_o(adc_clk_en_o),
    .irq_o(irq_o),
    .per_channel_dma_trigger_o(per_channel_dma_trigger_o),
    .any_channel_dma_trigger_o(any_channel_dma_trigger_o)
);

// File: sim/adc_sequencer_control_tb.sv
// Self-checking bench for the ADC sequencer control block
`timescale 1ns/1ps
`include "adc_seq_params.svh"

module adc_sequencer_control_tb;
    import adc_seq_pkg::*;
    localparam logic [7:0] A_CTL = `OFS_CTRL_FIRST;
    localparam logic [7:0] A_SEQ = `OFS_SEQ_CTRL;
    localparam logic [7:0] A_HI = `OFS_RESULT_HIGH;
    logic clk_i, nrst_i, wr, rd, ext_pin, tmr_evt, run, clk_en, irq, any_dma;
    logic [7:0] addr, wdata, rdata, got, per_dma, dma_mask, conv_cfg;
    logic [3:0] mux_ch;
    logic [1:0] ref_sel, dec_sel;
    result_t sample, pattern;
    int num_errors = 0, num_checks = 0, cycles = 0, dma_cnt = 0, irq_cnt = 0, seed = 87429;

    adc_sequencer_control i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ext_trig_pin_i(ext_pin),
        .timer_evt_i(tmr_evt), .sample_i(sample), .mux_ch_o(mux_ch), .ref_sel_o(ref_sel),
        .dec_sel_o(dec_sel), .conv_run_o(run), .adc_clk_en_o(clk_en), .irq_o(irq),
        .per_channel_dma_trigger_o(per_dma), .any_channel_dma_trigger_o(any_dma));
    adc_mod_model i_mod (.mux_ch_i(mux_ch), .conv_run_i(run), .pattern_i(pattern),
        .sample_o(sample));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////
    // Event monitor and hang guard, ceiling well above the planned run
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (any_dma) begin
            dma_cnt <= dma_cnt + 1;
            dma_mask <= dma_mask | per_dma;
        end
        if (irq) irq_cnt <= irq_cnt + 1;
        // Settings the modulator saw during the latest conversion
        if (run) conv_cfg <= {ref_sel, dec_sel, mux_ch};
        if (cycles == 90000) begin
            num_errors++;
            close_out();
        end
    end

    task close_out;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    task chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
            num_errors++;
        end
    endtask : chk

    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : wr_reg

    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1 got = rdata;
        chk(got, e);
    endtask : rd_chk

    task wait_done(input int dmas, input int irqs);
        int n;
        n = 0;
        while ((dma_cnt < dmas || irq_cnt < irqs) && n < 5000) begin
            @(posedge clk_i);
            n++;
        end
        repeat (20) @(posedge clk_i);
    endtask : wait_done

    function automatic logic [7:0] exp_hi(input logic [3:0] ch);
        result_t r;
        r = pattern ^ {ch, 10'h000};
        return r[13:6];
    endfunction : exp_hi

    // Resolution 8/10/12/13 bits for decimation codes 0..3; unresolved bits read zero
    function automatic logic [7:0] exp_lo(input logic [3:0] ch, input logic [1:0] div);
        result_t r;
        r = pattern ^ {ch, 10'h000};
        case (div)
            2'h0: r[5:0] = 6'h00;
            2'h1: r[3:0] = 4'h0;
            2'h2: r[1:0] = 2'h0;
            default: r[0] = 1'b0;
        endcase
        return {r[5:0], 2'b00};
    endfunction : exp_lo

    task start_test;
        dma_cnt = 0;
        irq_cnt = 0;
        dma_mask = 8'h00;
        pattern <= 14'($random(seed));
    endtask : start_test

    // Field f holds reference and decimation codes of the last conversion
    task check_result(input logic [3:0] ch, input logic [1:0] sel, input logic [3:0] f);
        chk(conv_cfg, {f, ch});
        rd_chk(A_CTL, {2'b10, sel, 4'h3});
        rd_chk(A_HI, exp_hi(ch));
        rd_chk(`OFS_RESULT_LOW, exp_lo(ch, f[1:0]));
        rd_chk(A_SEQ, {4'h0, ch});
        rd_chk(A_CTL, {2'b00, sel, 4'h3});
    endtask : check_result

    task run_seq(input logic [3:0] last, input logic [7:0] cfg, input logic [1:0] sel);
        logic [7:0] m;
        logic [3:0] fin;
        int n;
        bit inseq, en;
        m = 8'h00;
        fin = 4'h0;
        n = 0;
        for (int c = 0; c < 16; c++) begin
            inseq = (last < 8) ? (c <= last) : (last <= 12) ? (c >= 8 && c <= last) : (c == last);
            en = (c < 8) ? cfg[c] : (c < 12) ? (cfg[2*c-16] && cfg[2*c-15]) : 1'b1;
            if (inseq && en) begin
                n++;
                fin = 4'(c);
                if (c < 8) m[c] = 1'b1;
            end
        end
        start_test();
        wr_reg(`OFS_AIN_CFG, cfg);
        wr_reg(A_SEQ, {4'h0, last});
        wr_reg(A_CTL, {1'b0, sel == `START_SOURCE_SELECT_SW, sel, 4'h3});
        if (sel != `START_SOURCE_SELECT_SW) begin
            ext_pin <= (sel == `START_SOURCE_SELECT_EXT);
            tmr_evt <= (sel == `START_SOURCE_SELECT_TMR);
            @(posedge clk_i);
            tmr_evt <= 1'b0;
            repeat (3) @(posedge clk_i);
            ext_pin <= 1'b0;
        end
        wait_done(n, 0);
        chk(dma_mask, m);
        chk(8'(dma_cnt), 8'(n));
        chk(8'(irq_cnt), 8'h00);
        if (n > 0) check_result(fin, sel, 4'h0);
        else rd_chk(A_CTL, {2'b00, sel, 4'h3});
        $display("sequence test done last %h cfg %h source %h", last, cfg, sel);
    endtask : run_seq

    task run_extra(input logic [3:0] ch, input logic [3:0] f, input bit busy);
        start_test();
        if (busy) begin
            wr_reg(`OFS_AIN_CFG, 8'hff);
            wr_reg(A_SEQ, 8'h01);
            wr_reg(A_CTL, 8'h73);
        end
        wr_reg(`OFS_EXTRA_CTRL, {f, ch});
        wait_done(busy ? 2 : 0, 1);
        chk(8'(irq_cnt), 8'h01);
        chk(8'(dma_cnt), busy ? 8'h02 : 8'h00);
        chk(dma_mask, busy ? 8'h03 : 8'h00);
        check_result(ch, 2'h3, f);
        $display("extra test done channel %h fields %h busy %0d", ch, f, busy);
    endtask : run_extra

    ////////////////////////////////////////////////////////////////
    initial begin
        {nrst_i, wr, rd, ext_pin, tmr_evt} = 5'h00;
        addr = 8'h00;
        wdata = 8'h00;
        pattern = 14'h0000;
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd_chk(A_CTL, 8'h33);
        rd_chk(A_SEQ, 8'h10);
        rd_chk(`OFS_EXTRA_CTRL, 8'h00);
        rd_chk(`OFS_AIN_CFG, 8'h00);
        wr_reg(A_HI, 8'hff);
        rd_chk(A_HI, 8'h00);
        rd_chk(`OFS_RESULT_LOW, 8'h00);
        rd_chk(8'h00, 8'h00);
        // Start bit with another source selected must not launch
        start_test();
        wr_reg(A_CTL, 8'h43);
        repeat (600) @(posedge clk_i);
        chk(8'(dma_cnt), 8'h00);
        rd_chk(A_CTL, 8'h03);
        $display("reset and refusal test done");
        run_seq(4'h2, 8'h05, `START_SOURCE_SELECT_EXT);
        run_seq(4'h1, 8'h03, `START_SOURCE_SELECT_TMR);
        run_seq(4'h7, 8'h00, `START_SOURCE_SELECT_SW);
        run_seq(4'ha, 8'h3c, `START_SOURCE_SELECT_SW);
        run_seq(4'he, 8'h00, `START_SOURCE_SELECT_SW);
        repeat (5) run_seq(4'($random(seed)), 8'($random(seed)), `START_SOURCE_SELECT_SW);
        // Full speed restarts on its own; back to software source stops it after one more
        run_seq(4'h0, 8'h01, `START_SOURCE_SELECT_FULL);
        wr_reg(A_CTL, 8'h33);
        repeat (600) @(posedge clk_i);
        chk(8'(dma_cnt), 8'h02);
        $display("full speed restart test done");
        run_extra(4'($random(seed)), 4'($random(seed)), 1'b0);
        run_extra(4'hc, 4'h9, 1'b0);
        run_extra(4'h5, 4'h7, 1'b0);
        run_extra(4'h3, 4'he, 1'b1);
        close_out();
    end
endmodule : adc_sequencer_control_tb
